// *** logic/mcanc_top.sv ***
// module: autoneg mode control of the copper/fiber converter
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mcanc_top #(
	parameter logic [19:0] FLP_TIMEOUT = mcanc_pkg::FLP_TO_CYC
) (
	// clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire logic                 clk_en,
	// register port
	input  wire logic [4:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output var  logic [15:0]          reg_rdata,
	// configuration and control pins
	input  wire mcanc_pkg::mcanc_lvl_e speed_lvl,
	input  wire mcanc_pkg::mcanc_lvl_e duplex_lvl,
	input  wire logic [1:0]           copper_port_level_select,
	input  wire logic [1:0]           fiber_port_level_select,
	input  wire logic [1:0]           addr_hi_warn_pin,
	input  wire logic [1:0]           addr_mid_pin,
	input  wire logic [1:0]           addr_low_pin,
	input  wire logic                 copper_output_off_n,
	input  wire logic                 fiber_output_off_n,
	input  wire logic                 power_down_n,
	input  wire logic                 backup_link_pin_i,
	output var  logic                 backup_link_pin_o,
	output var  logic                 backup_link_pin_oe_n,
	output var  logic [5:0]           phy_addr,
	// line side
	input  wire mcanc_pkg::mcanc_lnk_s lnk,
	output var  mcanc_pkg::mcanc_phy_s phy,
	output var  mcanc_pkg::mcanc_ind_s ind
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0]            r28;
		logic [15:0]            r30;
		logic [15:0]            r31;
		logic [15:0]            rdata;
		logic [5:0]             lcnt;
		logic                   latched;
		logic [19:0]            cu_cnt;
		logic [19:0]            fo_cnt;
		mcanc_pkg::mcanc_mode_e mode;
		mcanc_pkg::mcanc_phy_s  phy;
		mcanc_pkg::mcanc_ind_s  ind;
		logic [5:0]             addr;
		logic                   bk_o;
		logic                   bk_oe_n;
	} mcanc_st_s;

	localparam mcanc_st_s ST_RST = '{
		r28: mcanc_pkg::REG_RST, r30: mcanc_pkg::REG_RST, r31: mcanc_pkg::REG_RST,
		rdata: 16'h0000, lcnt: 6'h00, latched: 1'b0, cu_cnt: 20'h00000, fo_cnt: 20'h00000,
		mode: mcanc_pkg::MODE_TRANSP, phy: '0, ind: '0, addr: 6'h00,
		bk_o: 1'b0, bk_oe_n: 1'b1};

	mcanc_st_s  st_q;
	mcanc_st_s  st_d;
	logic [1:0] rst_sync_q;
	logic       rst_n_s;

	// highest common ability, rank 100 full down to 10 half
	function automatic logic [2:0] mcanc_best(input logic [3:0] a, input logic [3:0] b);
		logic [3:0] c;
		c = a & b;
		if (c[3])
			mcanc_best = 3'h7;
		else if (c[2])
			mcanc_best = 3'h6;
		else if (c[1])
			mcanc_best = 3'h5;
		else if (c[0])
			mcanc_best = 3'h4;
		else
			mcanc_best = 3'h0;
	endfunction : mcanc_best

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n_s = rst_sync_q[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic        both_spd;
		logic        cu_cap;
		logic        fo_cap;
		logic        pd;
		logic [3:0]  adv;
		logic [2:0]  best;
		both_spd = 1'b0;
		cu_cap   = 1'b0;
		fo_cap   = 1'b0;
		pd       = 1'b0;
		adv      = 4'h0;
		best     = 3'h0;
		st_d     = st_q;
		// address pins are never latched, live except in hardware power down, which clears them to 0
		st_d.addr = {addr_hi_warn_pin, addr_mid_pin, addr_low_pin};
		if (!st_q.latched)
		begin
			st_d.lcnt = st_q.lcnt + 6'h01;
			if (st_q.lcnt == mcanc_pkg::LATCH_CYC - 6'h01)
			begin
				// pins decoded into registers once per reset or power-down release
				st_d.latched = 1'b1;
				st_d.r28[mcanc_pkg::R28_BACKUP] = backup_link_pin_i;
				st_d.r28[mcanc_pkg::R28_CU_LVL +: 2] = copper_port_level_select;
				st_d.r28[mcanc_pkg::R28_FO_LVL +: 2] = fiber_port_level_select;
				st_d.r30[mcanc_pkg::R30_LIW] = (addr_hi_warn_pin != 2'h0);
				st_d.r30[mcanc_pkg::R30_AN_DIS] = (speed_lvl != mcanc_pkg::LVL_MID);
				st_d.r30[mcanc_pkg::R30_SINGLE] = (speed_lvl != mcanc_pkg::LVL_MID);
				st_d.r30[mcanc_pkg::R30_SEL10] = (speed_lvl == mcanc_pkg::LVL_LOW);
				st_d.r30[mcanc_pkg::R30_PASS_N] = (duplex_lvl != mcanc_pkg::LVL_MID);
				st_d.r30[mcanc_pkg::R30_ADV_HALF_N] = 1'b0;
				st_d.r30[mcanc_pkg::R30_ADV_FULL_N] = (duplex_lvl == mcanc_pkg::LVL_LOW);
			end
		end
		// register writes override latched values, also in the latch cycle
		if (reg_wr)
		begin
			case (reg_addr)
				mcanc_pkg::REG28_IDX: st_d.r28 = reg_wdata;
				mcanc_pkg::REG30_IDX: st_d.r30 = reg_wdata;
				mcanc_pkg::REG31_IDX: st_d.r31 = reg_wdata;
				default: ;
			endcase
		end
		// partner capability: a burst seen within the timeout window
		if (lnk.cu_flp)
			st_d.cu_cnt = FLP_TIMEOUT;
		else if (st_q.cu_cnt != 20'h00000)
			st_d.cu_cnt = st_q.cu_cnt - 20'h00001;
		if (lnk.fo_flp)
			st_d.fo_cnt = FLP_TIMEOUT;
		else if (st_q.fo_cnt != 20'h00000)
			st_d.fo_cnt = st_q.fo_cnt - 20'h00001;
		cu_cap = (st_q.cu_cnt != 20'h00000);
		fo_cap = (st_q.fo_cnt != 20'h00000);
		both_spd = !st_q.r30[mcanc_pkg::R30_AN_DIS] && !st_q.r30[mcanc_pkg::R30_SINGLE];
		// mode selection
		if (!both_spd)
			st_d.mode = mcanc_pkg::MODE_FORCED;
		else if (!st_q.r30[mcanc_pkg::R30_PASS_N])
			st_d.mode = mcanc_pkg::MODE_TRANSP;
		else if (cu_cap && fo_cap)
			st_d.mode = mcanc_pkg::MODE_SPECIAL;
		else if (cu_cap && st_q.r30[mcanc_pkg::R30_ADV_FULL_N])
			st_d.mode = mcanc_pkg::MODE_NONT_HD;
		else if (cu_cap)
			st_d.mode = mcanc_pkg::MODE_NONTR;
		else
			st_d.mode = mcanc_pkg::MODE_TRANSP;
		// own abilities: detected fiber speed and selected duplex only
		adv[0] = !lnk.fo_spd100 && !st_q.r30[mcanc_pkg::R30_ADV_HALF_N];
		adv[1] = !lnk.fo_spd100 && !st_q.r30[mcanc_pkg::R30_ADV_FULL_N];
		adv[2] = lnk.fo_spd100 && !st_q.r30[mcanc_pkg::R30_ADV_HALF_N];
		adv[3] = lnk.fo_spd100 && !st_q.r30[mcanc_pkg::R30_ADV_FULL_N];
		st_d.phy = '0;
		// data paths are separate and duplex-agnostic in every mode
		st_d.phy.fo_tx_100 = lnk.cu_spd100;
		st_d.phy.cu_tx_100 = lnk.fo_spd100;
		case (st_q.mode)
			mcanc_pkg::MODE_NONTR, mcanc_pkg::MODE_NONT_HD:
			begin
				st_d.phy.cu_tx_en = lnk.cu_sig && lnk.fo_sig;
				st_d.phy.fo_tx_en = 1'b1;
				st_d.phy.flp_gen  = cu_cap && !fo_cap;
				if (st_q.mode == mcanc_pkg::MODE_NONT_HD)
					st_d.phy.flp_abil = adv & 4'h5;
				else
					st_d.phy.flp_abil = adv;
				best = mcanc_best(st_d.phy.flp_abil, lnk.cu_abil);
			end
			mcanc_pkg::MODE_TRANSP, mcanc_pkg::MODE_SPECIAL:
			begin
				st_d.phy.cu_tx_en = lnk.fo_sig;
				st_d.phy.fo_tx_en = lnk.cu_sig;
				st_d.phy.relay_en = 1'b1;
			end
			mcanc_pkg::MODE_FORCED:
			begin
				st_d.phy.cu_tx_en = lnk.fo_sig;
				st_d.phy.fo_tx_en = lnk.cu_sig;
				st_d.phy.liw_en   = st_q.r30[mcanc_pkg::R30_LIW];
			end
			default:
			begin
				st_d.phy.cu_tx_en = 1'b0;
				st_d.phy.fo_tx_en = 1'b0;
			end
		endcase
		st_d.phy.res_valid = best[2];
		st_d.phy.res_abil  = best[1:0];
		// output-off pins and bits act in every mode
		if (!copper_output_off_n || st_q.r31[mcanc_pkg::R31_CU_OFF])
			st_d.phy.cu_tx_en = 1'b0;
		if (!fiber_output_off_n || st_q.r31[mcanc_pkg::R31_FO_OFF])
			st_d.phy.fo_tx_en = 1'b0;
		// soft power down keeps registers, indicators and backup pin running, silences the phy outputs
		pd = st_q.r31[mcanc_pkg::R31_PWR_DOWN] || !st_q.latched;
		if (pd)
			st_d.phy = '0;
		st_d.ind.copper_input_speed_ind = lnk.cu_spd100 && lnk.cu_sig;
		st_d.ind.fiber_input_speed_ind  = lnk.fo_spd100 && lnk.fo_sig;
		st_d.ind.copper_neg_indicator   = cu_cap;
		st_d.ind.fiber_neg_indicator    = fo_cap;
		// backup pin turns into an output once its strap is taken
		st_d.bk_oe_n = !st_q.latched;
		st_d.bk_o    = lnk.fo_sig;
		// read data valid only in the cycle after the strobe
		st_d.rdata = 16'h0000;
		if (reg_rd)
		begin
			case (reg_addr)
				mcanc_pkg::REG28_IDX: st_d.rdata = st_q.r28;
				mcanc_pkg::REG30_IDX: st_d.rdata = st_q.r30;
				mcanc_pkg::REG31_IDX: st_d.rdata = st_q.r31;
				mcanc_pkg::STAT_IDX:
					st_d.rdata = {6'h00, st_q.phy.res_valid, st_q.phy.res_abil,
						st_q.phy.flp_gen, fo_cap, cu_cap, st_q.latched, st_q.mode};
				default: st_d.rdata = 16'h0000;
			endcase
		end
		// hardware power down: everything back to reset, relatch on release
		if (!power_down_n)
			st_d = ST_RST;
	end

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			st_q <= ST_RST;
		else if (clk_en)
			st_q <= st_d;
	end

	assign reg_rdata            = st_q.rdata;
	assign phy                  = st_q.phy;
	assign ind                  = st_q.ind;
	assign phy_addr             = st_q.addr;
	assign backup_link_pin_o    = st_q.bk_o;
	assign backup_link_pin_oe_n = st_q.bk_oe_n;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	nontr_cu_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && (st_q.mode == mcanc_pkg::MODE_NONTR) && !(lnk.cu_sig && lnk.fo_sig))
		|=> !phy.cu_tx_en)
		else $error("copper output on before both signals detected");
	nontr_fo_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && (st_q.mode == mcanc_pkg::MODE_NONTR) && fiber_output_off_n && power_down_n
		&& !st_q.r31[mcanc_pkg::R31_FO_OFF] && !st_q.r31[mcanc_pkg::R31_PWR_DOWN])
		|=> phy.fo_tx_en)
		else $error("fiber output off in non-transparent mode");
	flp_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		phy.flp_gen |-> (st_q.cu_cnt != 20'h00000) || $past(st_q.cu_cnt) != 20'h00000)
		else $error("own bursts without copper bursts");
	hd_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && (st_q.mode == mcanc_pkg::MODE_NONT_HD)) |=> (phy.flp_abil[3] == 1'b0
		&& phy.flp_abil[1] == 1'b0))
		else $error("full duplex advertised in half-duplex variant");
	liw_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && (st_q.mode != mcanc_pkg::MODE_FORCED)) |=> !phy.liw_en)
		else $error("warning enabled outside forced mode");
	transp_relay_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		phy.relay_en |-> !phy.flp_gen && phy.flp_abil == 4'h0)
		else $error("own content while relaying");
	fo_supp_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && lnk.fo_flp) ##1 clk_en |=> !phy.flp_gen)
		else $error("own bursts despite fiber bursts");
	res_best_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		(clk_en && (st_q.mode == mcanc_pkg::MODE_NONTR) && lnk.fo_spd100
		&& !st_q.r30[mcanc_pkg::R30_ADV_FULL_N] && lnk.cu_abil[3] && !st_q.r30[mcanc_pkg::R30_PASS_N]
		== 1'b0 && power_down_n && !st_q.r31[mcanc_pkg::R31_PWR_DOWN])
		|=> phy.res_valid && phy.res_abil == 2'h3)
		else $error("resolution missed highest common ability");
	latch_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		$rose(st_q.latched) |-> $past(st_q.lcnt) == mcanc_pkg::LATCH_CYC - 6'h01)
		else $error("pins latched at wrong time");
	bk_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
		st_q.latched |-> !backup_link_pin_oe_n || $rose(st_q.latched))
		else $error("backup pin not driven after latch");
	nontr_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
		st_q.mode == mcanc_pkg::MODE_NONTR && phy.flp_gen);
	special_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
		st_q.mode == mcanc_pkg::MODE_SPECIAL);
	hd_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
		st_q.mode == mcanc_pkg::MODE_NONT_HD && phy.flp_gen);
endmodule : mcanc_top
`default_nettype wire

// *** logic/mcanc_pkg.sv ***
// package: constants and carriers for the autoneg mode control block
package mcanc_pkg;
	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam logic [4:0]  REG28_IDX      = 5'h1c;
	localparam logic [4:0]  STAT_IDX       = 5'h1d;
	localparam logic [4:0]  REG30_IDX      = 5'h1e;
	localparam logic [4:0]  REG31_IDX      = 5'h1f;
	localparam int          R28_BACKUP     = 1;
	localparam int          R28_CU_LVL     = 2;
	localparam int          R28_FO_LVL     = 4;
	localparam int          R30_ADV_HALF_N = 15;
	localparam int          R30_AN_DIS     = 14;
	localparam int          R30_LIW        = 12;
	localparam int          R30_PASS_N     = 11;
	localparam int          R30_ADV_FULL_N = 10;
	localparam int          R30_SEL10      = 8;
	localparam int          R30_SINGLE     = 0;
	localparam int          R31_PWR_DOWN   = 15;
	localparam int          R31_FO_OFF     = 14;
	localparam int          R31_CU_OFF     = 13;
	localparam logic [15:0] REG_RST        = 16'h0000;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          LATCH_MIN_NS   = 3000;
	localparam logic [5:0]  LATCH_CYC      = 6'((LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int          FLP_TO_US      = 50000;
	localparam logic [19:0] FLP_TO_CYC     = 20'(FLP_TO_US * 1000 / CLK_PERIOD_NS);
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {LVL_LOW = 2'h0, LVL_MID = 2'h1, LVL_HIGH = 2'h2} mcanc_lvl_e;
	typedef enum logic [2:0] {
		MODE_FORCED  = 3'h0,
		MODE_TRANSP  = 3'h1,
		MODE_NONTR   = 3'h2,
		MODE_NONT_HD = 3'h3,
		MODE_SPECIAL = 3'h4
	} mcanc_mode_e;
	// abilities: [3] 100 full, [2] 100 half, [1] 10 full, [0] 10 half
	typedef struct packed {
		logic       cu_sig;
		logic       fo_sig;
		logic       cu_flp;
		logic       fo_flp;
		logic       cu_spd100;
		logic       fo_spd100;
		logic [3:0] cu_abil;
	} mcanc_lnk_s;
	typedef struct packed {
		logic       cu_tx_en;
		logic       cu_tx_100;
		logic       fo_tx_en;
		logic       fo_tx_100;
		logic       flp_gen;
		logic [3:0] flp_abil;
		logic       relay_en;
		logic       liw_en;
		logic       res_valid;
		logic [1:0] res_abil;
	} mcanc_phy_s;
	typedef struct packed {
		logic copper_input_speed_ind;
		logic fiber_input_speed_ind;
		logic copper_neg_indicator;
		logic fiber_neg_indicator;
	} mcanc_ind_s;
endpackage : mcanc_pkg

// *** dv/mcanc_partner.sv ***
// link partner model: copper and fiber burst sources and line status
`timescale 1ns/1ps
`default_nettype none
module mcanc_partner #(
	parameter int BURST_GAP = 8
) (
	// clock
	input  wire logic                  ref_clk,
	// scenario control, bit 1 copper, bit 0 fiber
	input  wire logic                  cu_neg_on,
	input  wire logic                  fo_neg_on,
	input  wire logic [1:0]            sig_on,
	input  wire logic [1:0]            spd100,
	input  wire logic [3:0]            cu_abil,
	// line side
	output var  mcanc_pkg::mcanc_lnk_s lnk
);
	// known start so the burst phase counter never locks at unknown
	logic [7:0] gap_q = 8'h00;

	always @(posedge ref_clk)
	begin
		gap_q <= (gap_q == 8'(BURST_GAP - 1)) ? 8'h00 : gap_q + 8'h01;
		// bursts run only while the partner itself wants to negotiate
		lnk.cu_flp    <= cu_neg_on && (gap_q == 8'h00);
		// fiber bursts sit off the copper phase so both can be seen
		lnk.fo_flp    <= fo_neg_on && (gap_q == 8'h04);
		lnk.cu_sig    <= sig_on[1];
		lnk.fo_sig    <= sig_on[0];
		lnk.cu_spd100 <= spd100[1];
		lnk.fo_spd100 <= spd100[0];
		lnk.cu_abil   <= cu_abil;
	end
endmodule : mcanc_partner
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench: scenarios for the autoneg mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                  ref_clk, resetn, clk_en, reg_wr, reg_rd;
	logic [4:0]            reg_addr;
	logic [15:0]           reg_wdata, reg_rdata, rdv;
	mcanc_pkg::mcanc_lvl_e speed_lvl, duplex_lvl;
	logic [1:0]            cu_lvl, fo_lvl, a_hi, a_mid, a_lo, sig_on, spd100;
	logic                  cu_off_n, fo_off_n, power_down_n, bk_i, bk_o, bk_oe_n;
	logic                  cu_neg_on, fo_neg_on;
	logic [5:0]            phy_addr;
	logic [3:0]            cu_abil;
	mcanc_pkg::mcanc_lnk_s lnk;
	mcanc_pkg::mcanc_phy_s phy;
	mcanc_pkg::mcanc_ind_s ind;
	int                    miscompares, checked;
	// ------------------------------------------------------------
	// instances
	// ------------------------------------------------------------
	// short burst timeout keeps the run brief
	mcanc_top #(.FLP_TIMEOUT(20'd20)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_lvl(speed_lvl),
		.duplex_lvl(duplex_lvl), .copper_port_level_select(cu_lvl),
		.fiber_port_level_select(fo_lvl), .addr_hi_warn_pin(a_hi), .addr_mid_pin(a_mid),
		.addr_low_pin(a_lo), .copper_output_off_n(cu_off_n), .fiber_output_off_n(fo_off_n),
		.power_down_n(power_down_n), .backup_link_pin_i(bk_i), .backup_link_pin_o(bk_o),
		.backup_link_pin_oe_n(bk_oe_n), .phy_addr(phy_addr), .lnk(lnk), .phy(phy),
		.ind(ind));
	mcanc_partner u_partner (.ref_clk(ref_clk), .cu_neg_on(cu_neg_on), .fo_neg_on(fo_neg_on),
		.sig_on(sig_on), .spd100(spd100), .cu_abil(cu_abil), .lnk(lnk));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cycles
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask : rd
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_strap();
		rd(mcanc_pkg::REG30_IDX);
		chk(rdv & 16'hdd01, 16'h1000, "strap r30");
		rd(mcanc_pkg::REG28_IDX);
		chk(rdv & 16'h003e, 16'h0026, "strap r28");
		rd(mcanc_pkg::STAT_IDX);
		chk(rdv & 16'h000f, 16'h0009, "strap mode");
		chk(16'(phy_addr), 16'h001b, "address");
		chk(16'({bk_oe_n, bk_o}), 16'h0001, "backup out");
	endtask : t_strap
	task automatic t_transp();
		@(posedge ref_clk);
		cu_neg_on <= 1'b1;
		fo_neg_on <= 1'b1;
		cycles(14);
		chk(16'({phy.relay_en, phy.flp_gen}), 16'h0002, "relay only");
		chk(16'({phy.cu_tx_100, phy.fo_tx_100}), 16'h0001, "cross speed");
		chk(16'(phy.liw_en), 16'h0000, "warning off");
		chk(16'(ind), 16'h000b, "indicators");
		@(posedge ref_clk);
		fo_neg_on <= 1'b0;
	endtask : t_transp
	task automatic t_nontr();
		wr(mcanc_pkg::REG30_IDX, 16'h1800);
		cycles(40);
		rd(mcanc_pkg::STAT_IDX);
		chk(rdv & 16'h0007, 16'h0002, "nontr mode");
		chk(16'({phy.flp_gen, phy.flp_abil}), 16'h0013, "own bursts");
		chk(16'({phy.cu_tx_en, phy.fo_tx_en, phy.liw_en}), 16'h0006, "tx gates");
		chk(16'(phy.res_valid), 16'h0001, "res valid");
		chk(16'(phy.res_abil), 16'h0001, "res 10 full");
		@(posedge ref_clk);
		sig_on  <= 2'b10;
		spd100  <= 2'b11;
		cu_abil <= 4'h7;
		cycles(5);
		chk(16'({phy.cu_tx_en, phy.fo_tx_en, bk_o}), 16'h0002, "fiber lost");
		chk(16'({phy.flp_abil, phy.res_abil}), 16'h0032, "100 advert");
		@(posedge ref_clk);
		sig_on   <= 2'b11;
		cu_off_n <= 1'b0;
		cycles(5);
		chk(16'({phy.cu_tx_en, phy.fo_tx_en}), 16'h0001, "copper off pin");
		@(posedge ref_clk);
		cu_off_n  <= 1'b1;
		cu_neg_on <= 1'b0;
		cycles(8);
		chk(16'(phy.flp_gen), 16'h0001, "bursts linger");
		cycles(25);
		chk(16'(phy.flp_gen), 16'h0000, "bursts stop");
	endtask : t_nontr
	task automatic t_special();
		@(posedge ref_clk);
		cu_neg_on <= 1'b1;
		fo_neg_on <= 1'b1;
		cycles(14);
		rd(mcanc_pkg::STAT_IDX);
		chk(rdv & 16'h0007, 16'h0004, "special mode");
		chk(16'({phy.relay_en, phy.flp_gen}), 16'h0002, "suppressed");
		@(posedge ref_clk);
		cu_neg_on <= 1'b0;
		fo_neg_on <= 1'b0;
	endtask : t_special
	task automatic t_regs();
		rd(5'h03);
		chk(rdv, 16'h0000, "unmapped read");
		wr(5'h05, 16'hffff);
		wr(mcanc_pkg::STAT_IDX, 16'hffff);
		rd(mcanc_pkg::REG30_IDX);
		chk(rdv & 16'hdd01, 16'h1800, "r30 kept");
		wr(mcanc_pkg::REG31_IDX, 16'h6000);
		rd(mcanc_pkg::REG31_IDX);
		chk(rdv & 16'he000, 16'h6000, "r31 back");
		cycles(4);
		chk(16'({phy.cu_tx_en, phy.fo_tx_en}), 16'h0000, "soft off");
		wr(mcanc_pkg::REG31_IDX, 16'h0000);
		// forced mode is the only place the warning may come on
		wr(mcanc_pkg::REG30_IDX, 16'h5001);
		cycles(4);
		chk(16'(phy.liw_en), 16'h0001, "forced warning");
		// clock enable low freezes every output
		@(posedge ref_clk);
		clk_en <= 1'b0;
		sig_on <= 2'b00;
		cycles(4);
		chk(16'({phy.cu_tx_en, phy.fo_tx_en}), 16'h0003, "frozen");
		@(posedge ref_clk);
		clk_en <= 1'b1;
		cycles(4);
		chk(16'({phy.cu_tx_en, phy.fo_tx_en}), 16'h0000, "thawed");
		@(posedge ref_clk);
		sig_on <= 2'b11;
	endtask : t_regs
	task automatic t_relatch();
		@(posedge ref_clk);
		duplex_lvl   <= mcanc_pkg::LVL_LOW;
		a_hi         <= 2'h0;
		power_down_n <= 1'b0;
		cycles(5);
		@(posedge ref_clk);
		power_down_n <= 1'b1;
		cycles(40);
		rd(mcanc_pkg::REG30_IDX);
		chk(rdv & 16'hdd01, 16'h0c00, "relatch r30");
		chk(16'(phy_addr), 16'h000b, "live address");
		@(posedge ref_clk);
		cu_neg_on <= 1'b1;
		cycles(14);
		rd(mcanc_pkg::STAT_IDX);
		chk(rdv & 16'h0007, 16'h0003, "half mode");
		chk(16'({phy.flp_abil, phy.fo_tx_en}), 16'h0009, "half advert");
	endtask : t_relatch
	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		{miscompares, checked} = '0;
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{clk_en, cu_off_n, fo_off_n, power_down_n, bk_i} = 5'h1f;
		speed_lvl = mcanc_pkg::LVL_MID;
		duplex_lvl = mcanc_pkg::LVL_MID;
		{cu_lvl, fo_lvl, a_hi, a_mid, a_lo} = 10'h19b;
		{cu_neg_on, fo_neg_on} = 2'h0;
		sig_on = 2'b11;
		spd100 = 2'b10;
		cu_abil = 4'hf;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		cycles(40);
		t_strap();
		t_transp();
		t_nontr();
		t_special();
		t_regs();
		t_relatch();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
